// ==== core/frame_if.sv ====
// carrier between the link-side shifter and the command core
// rx_word and frame_full are only read while chip select is high and the link clock idle
`timescale 1ns/100ps
interface frame_if #(parameter int W = 16);
    logic [W-1:0] rx_word;
    logic frame_full;
    logic [W-1:0] resp_word;

    modport port (output rx_word, output frame_full, input resp_word);
    modport core (input rx_word, input frame_full, output resp_word);
endinterface

// ==== core/spi_frame_port.sv ====
// serial shifter on the link clock: captures one frame, shifts out the held response
// assumes clock idles low, data driven on rising edge and sampled on falling edge
`timescale 1ns/100ps
module spi_frame_port
    import wd_cmd_pkg::*;
#(
    parameter int W = FRAME_BITS
)
(
    // link pins
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    // toward the command core
    frame_if.port link
);

    localparam int CNT_W = $clog2(W + 2);
    localparam int IDX_W = $clog2(W);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(W);
    localparam logic [CNT_W-1:0] CNT_OVER = CNT_W'(W + 1);
    localparam logic [IDX_W-1:0] IDX_TOP = IDX_W'(W - 1);

    logic [CNT_W-1:0] cnt_reg;
    logic [W-1:0] rx_reg;
    logic full_reg;
    logic miso_reg;
    logic [IDX_W-1:0] bit_idx;

    assign bit_idx = IDX_TOP - IDX_W'(cnt_reg);

    // edge count; chip select ends the frame, overlong frames saturate and are rejected
    always_ff @(posedge spi_sclk or posedge spi_cs_n)
    begin
        if (spi_cs_n)
            cnt_reg <= '0;
        else if (cnt_reg != CNT_OVER)
            cnt_reg <= cnt_reg + 1'b1;
    end

    // response bits out, msb first; low between frames
    always_ff @(posedge spi_sclk or posedge spi_cs_n)
    begin
        if (spi_cs_n)
            miso_reg <= 1'b0;
        else if (cnt_reg < CNT_FULL)
            miso_reg <= link.resp_word[bit_idx];
        else
            miso_reg <= 1'b0;
    end

    // command bits in; no reset needed, the core only looks after a closed frame
    always_ff @(negedge spi_sclk)
    begin
        rx_reg <= {rx_reg[W-2:0], spi_mosi};
        full_reg <= (cnt_reg == CNT_FULL); // exact length only
    end

    assign link.rx_word = rx_reg;
    assign link.frame_full = full_reg;
    assign spi_miso = miso_reg;

endmodule

// ==== core/status_latch.sv ====
// sticky status bits that hold their active level until cleared
// assumes cond is already synchronous to clk
`timescale 1ns/100ps
module status_latch
    import wd_cmd_pkg::*;
#(
    parameter int N = 2,
    parameter logic [N-1:0] ACTIVE = '1
)
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // clear request and live conditions
    input wire logic clear,
    input wire logic [N-1:0] cond,
    // latched view
    output logic [N-1:0] latched
);

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_bit
            // sticky capture
            // an active condition wins over a clear in the same cycle, so nothing is lost
            always_ff @(posedge clk)
            begin
                if (srst)
                    latched[i] <= ~ACTIVE[i];
                else if (cond[i] == ACTIVE[i])
                    latched[i] <= ACTIVE[i];
                else if (clear)
                    latched[i] <= ~ACTIVE[i];
            end

            latch_capture_a: assert property (cond[i] == ACTIVE[i] |=> latched[i] == ACTIVE[i])
                else $error("active condition not latched");
            latch_hold_a: assert property ((latched[i] == ACTIVE[i]) && !clear
                |=> (latched[i] == ACTIVE[i]) [*1])
                else $error("latched bit dropped without clear");
            latch_release_a: assert property (clear && (cond[i] != ACTIVE[i]) ##1
                (cond[i] == ACTIVE[i]) |=> latched[i] == ACTIVE[i])
                else $error("bit did not follow condition after clear");
            latch_clear_a: assert property (clear && (cond[i] != ACTIVE[i])
                |=> latched[i] == ~ACTIVE[i])
                else $error("clear did not return bit to inactive");
        end
    endgenerate

endmodule

// ==== core/watchdog_diag_status_commands.sv ====
// command core for watchdog service, watchdog self-test, diagnostic default and status read
// assumes the watchdog state machine and diagnostic blocks sit on ref_clk outside this block;
// the host keeps chip select high for at least eight ref_clk periods between frames
//
// What this block does
// - accept only 0x55 low, 0xAA high service
// - self-test write forces wait-for-failure state
// - accepted writes answer ack, data zero
// - reading write-only command answers request error
// - diagnostic default resets analog and sensor controls
// - status read-only; write answers request error
// - status byte layout, temperatures down to cause
// - boost and ignition bits latch when active
// - status read or reset releases, then follow
// - watchdog state bits use four-code encoding
// - bad refresh sets cause; reset or good clears
// - cause bit one means watchdog caused reset
// - other service values leave watchdog untouched
`timescale 1ns/100ps
module watchdog_diag_status_commands
    import wd_cmd_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // serial link
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    // raw status pins, asynchronous
    input wire logic sync_supply_overtemp,
    input wire logic dc_sensor_reg_overtemp,
    input wire logic boost_overtemp,
    input wire logic ignition_level_monitor,
    input wire logic wake_pin_level,
    // watchdog state machine, same clock
    input wire logic [1:0] wd_state,
    input wire logic wd_refresh_bad,
    input wire logic wd_refresh_good,
    input wire logic wd_sm_reset,
    input wire logic internal_reset,
    // command pulses, one cycle each
    output logic watchdog_service_low,
    output logic watchdog_service_high,
    output logic watchdog_selftest_cmd,
    output logic diagnostic_default_cmd
);

    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    frame_if #(.W(FRAME_BITS)) link ();

    // link-side shifter runs on the link clock
    spi_frame_port #(
        .W(FRAME_BITS)
    ) u_port (
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .link(link)
    );

    // pin synchronisers; only the second stage is read
    logic [5:0] pin_raw;
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic cs_last_reg;

    assign pin_raw = {spi_cs_n, sync_supply_overtemp, dc_sensor_reg_overtemp,
                      boost_overtemp, ignition_level_monitor, wake_pin_level};

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            sync1_reg <= PIN_SYNC_RESET;
            sync2_reg <= PIN_SYNC_RESET;
        end
        else
        begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // chip select history for the end-of-frame edge
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            cs_last_reg <= 1'b1;
        else
            cs_last_reg <= sync2_reg[PIN_CS];
    end

    // a frame is taken when select rises after exactly one full word;
    // the word itself is quiet by then since the link clock has stopped
    logic cs_rise;
    logic frame_take;
    logic [1:0] rx_op;
    logic [5:0] rx_id;
    logic [7:0] rx_data;

    assign cs_rise = sync2_reg[PIN_CS] & ~cs_last_reg;
    assign frame_take = cs_rise & link.frame_full;
    assign rx_op = link.rx_word[15:14];
    assign rx_id = link.rx_word[13:8];
    assign rx_data = link.rx_word[7:0];

    // command decode
    logic is_wr;
    logic is_rd;
    logic hit_svc;
    logic hit_test;
    logic hit_diag;
    logic hit_stat;
    logic hit_wo;
    logic take_svc_wr;
    logic take_test_wr;
    logic take_diag_wr;
    logic take_stat_rd;
    logic take_stat_wr;
    logic take_wo_rd;

    assign is_wr = (rx_op == OP_WRITE);
    assign is_rd = (rx_op == OP_READ);
    assign hit_svc = (rx_id == ID_SERVICE);
    assign hit_test = (rx_id == ID_SELFTEST);
    assign hit_diag = (rx_id == ID_DIAG_DEFAULT);
    assign hit_stat = (rx_id == ID_STATUS);
    assign hit_wo = hit_svc | hit_test | hit_diag;
    assign take_svc_wr = frame_take & is_wr & hit_svc;
    assign take_test_wr = frame_take & is_wr & hit_test;
    assign take_diag_wr = frame_take & is_wr & hit_diag;
    assign take_stat_rd = frame_take & is_rd & hit_stat;
    assign take_stat_wr = frame_take & is_wr & hit_stat;
    assign take_wo_rd = frame_take & is_rd & hit_wo;

    // watchdog reset cause: a bad refresh in the same cycle as a clear wins
    logic wdr_reg;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            wdr_reg <= 1'b0;
        else if (wd_refresh_bad)
            wdr_reg <= 1'b1;
        else if (wd_refresh_good | wd_sm_reset)
            wdr_reg <= 1'b0;
    end

    // sticky boost and ignition bits, released by a status read or internal reset
    logic [1:0] latch_cond;
    logic [1:0] latch_q;
    logic latch_clear;

    assign latch_cond = {sync2_reg[PIN_BOT], sync2_reg[PIN_IGN]};
    assign latch_clear = take_stat_rd | internal_reset;

    status_latch #(
        .N(2),
        .ACTIVE(LATCH_ACTIVE)
    ) u_latch (
        .clk(ref_clk),
        .srst(srst),
        .clear(latch_clear),
        .cond(latch_cond),
        .latched(latch_q)
    );

    logic [7:0] status_vec;
    wd_state_t wd_state_e;

    assign wd_state_e = wd_state_t'(wd_state);
    assign status_vec = {sync2_reg[PIN_SOT], sync2_reg[PIN_DC_SENSOR_REG_OVERTEMP], latch_q[LATCH_BOT],
                         latch_q[LATCH_IGN], sync2_reg[PIN_WAKE], wd_state_e, wdr_reg};

    // response selection; anything not ours or in the wrong direction is an error
    logic [15:0] resp_next;
    logic [15:0] resp_reg;

    always_comb
    begin
        resp_next = build_resp(HDR_ERROR, DATA_REQ_ERR);
        if (is_wr && hit_wo)
            resp_next = build_resp(HDR_ACK, DATA_ZERO);
        else if (is_rd && hit_stat)
            resp_next = build_resp(HDR_READ, status_vec);
    end

    // response held for the whole next frame; the shifter reads it on the link clock
    // response framing
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            resp_reg <= RESP_RESET;
        else if (frame_take)
            resp_reg <= resp_next;
    end

    assign link.resp_word = resp_reg;

    // service pulses; values other than the two service codes do nothing
    // service value match
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            watchdog_service_low <= 1'b0;
            watchdog_service_high <= 1'b0;
        end
        else
        begin
            watchdog_service_low <= take_svc_wr & (rx_data == SVC_LOW);
            watchdog_service_high <= take_svc_wr & (rx_data == SVC_HIGH);
        end
    end

    // self-test and diagnostic default pulses
    // self-test request pulse
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            watchdog_selftest_cmd <= 1'b0;
            diagnostic_default_cmd <= 1'b0;
        end
        else
        begin
            watchdog_selftest_cmd <= take_test_wr;
            diagnostic_default_cmd <= take_diag_wr;
        end
    end

    svc_low_a: assert property (take_svc_wr && rx_data == SVC_LOW
        |=> watchdog_service_low && !watchdog_service_high)
        else $error("low service value not passed on");
    svc_high_a: assert property (take_svc_wr && rx_data == SVC_HIGH
        |=> watchdog_service_high && !watchdog_service_low)
        else $error("high service value not passed on");
    svc_other_a: assert property (take_svc_wr && rx_data != SVC_LOW && rx_data != SVC_HIGH
        |=> !watchdog_service_low && !watchdog_service_high)
        else $error("stray service value reached watchdog");
    svc_source_a: assert property (watchdog_service_low || watchdog_service_high
        |-> $past(take_svc_wr))
        else $error("service pulse without service command");
    selftest_pulse_a: assert property (take_test_wr
        |=> watchdog_selftest_cmd ##1 (!watchdog_selftest_cmd || $past(take_test_wr)))
        else $error("self-test pulse wrong");
    diag_pulse_a: assert property (diagnostic_default_cmd == $past(take_diag_wr))
        else $error("diagnostic default pulse wrong");
    write_ack_a: assert property (frame_take && is_wr && hit_wo
        |=> resp_reg[15:13] == HDR_ACK && resp_reg[7:0] == DATA_ZERO)
        else $error("write acknowledge wrong");
    wo_read_err_a: assert property (take_wo_rd
        |=> resp_reg[15:13] == HDR_ERROR && resp_reg[7:0] == DATA_REQ_ERR)
        else $error("read of write-only command not refused");
    stat_write_err_a: assert property (take_stat_wr
        |=> resp_reg[15:13] == HDR_ERROR && resp_reg[7:0] == DATA_REQ_ERR)
        else $error("status write not refused");
    // status read returns the assembled byte
    stat_read_a: assert property (take_stat_rd
        |=> resp_reg[15:13] == HDR_READ && resp_reg[7:0] == $past(status_vec))
        else $error("status read data wrong");
    wd_code_a: assert property (take_stat_rd |=> resp_reg[2:1] == $past(wd_state))
        else $error("watchdog state bits misplaced");
    wdr_set_a: assert property (wd_refresh_bad |=> wdr_reg)
        else $error("bad refresh did not set cause");
    wdr_clear_a: assert property (!wd_refresh_bad && (wd_refresh_good || wd_sm_reset)
        |=> !wdr_reg)
        else $error("cause not cleared");
    wdr_hold_a: assert property (!wd_refresh_bad && !wd_refresh_good && !wd_sm_reset
        |=> $stable(wdr_reg))
        else $error("cause changed without event");
    // framing and odd parity, held between frames
    resp_format_a: assert property (resp_reg[11:8] == RESP_FIXED && (^resp_reg))
        else $error("response framing or parity wrong");
    resp_hold_a: assert property (!frame_take |=> $stable(resp_reg))
        else $error("response changed without frame");

endmodule

// ==== core/wd_cmd_pkg.sv ====
// constants, types and the response builder for the watchdog, diagnostic and status commands
// assumes 16-bit frames: op in bits 15:14, command id in 13:8, data in 7:0
package wd_cmd_pkg;

    // frame geometry
    localparam int FRAME_BITS = 16;
    localparam int SYNC_STAGES = 2;

    // operation field of a received frame
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;

    // command ids, shared by the write and the read code of each command
    localparam logic [5:0] ID_SERVICE = 6'h0E;
    localparam logic [5:0] ID_SELFTEST = 6'h15;
    localparam logic [5:0] ID_DIAG_DEFAULT = 6'h14;
    localparam logic [5:0] ID_STATUS = 6'h16;

    // response header and fixed field
    localparam logic [2:0] HDR_ACK = 3'h1;
    localparam logic [2:0] HDR_READ = 3'h2;
    localparam logic [2:0] HDR_ERROR = 3'h0;
    localparam logic [3:0] RESP_FIXED = 4'hE;
    localparam int PARITY_BIT = 12;

    // data values
    localparam logic [7:0] SVC_LOW = 8'h55;
    localparam logic [7:0] SVC_HIGH = 8'hAA;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [7:0] DATA_REQ_ERR = 8'h02;

    // response shown before the first decoded frame: error header, no data
    localparam logic [15:0] RESP_RESET = 16'h0E00;

    // synchroniser reset: {cs_n, sot, dc_sensor_reg_overtemp, bot, ign, wake} at their idle levels
    localparam logic [5:0] PIN_SYNC_RESET = 6'h23;
    localparam int PIN_CS = 5;
    localparam int PIN_SOT = 4;
    localparam int PIN_DC_SENSOR_REG_OVERTEMP = 3;
    localparam int PIN_BOT = 2;
    localparam int PIN_IGN = 1;
    localparam int PIN_WAKE = 0;

    // latched status bits: bit 1 boost overtemp (active 1), bit 0 ignition (active 0)
    localparam logic [1:0] LATCH_ACTIVE = 2'h2;
    localparam int LATCH_BOT = 1;
    localparam int LATCH_IGN = 0;

    // watchdog state encoding as reported in the status word
    typedef enum logic [1:0] {
        WD_INITIAL = 2'h0,
        WD_DRIVE_UNLOCKED = 2'h1,
        WD_DRIVE_LOCKED = 2'h2,
        WD_TEST_OVERRIDE = 2'h3
    } wd_state_t;

    // response word with odd parity over all sixteen bits
    function automatic logic [15:0] build_resp(input logic [2:0] hdr, input logic [7:0] data);
        logic [15:0] w;
        w = {hdr, 1'b0, RESP_FIXED, data};
        w[PARITY_BIT] = ~(^w);
        return w;
    endfunction

endpackage

// ==== testbench/spi_host_model.sv ====
// host side of the serial link: sends one frame per call and collects the reply
// assumes clock idles low, data launched on rising and sampled on falling sclk edge
`timescale 1ns/100ps
module spi_host_model
(
    // link pins
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    localparam int HALF = 15;
    localparam int GAP = 200;

    // idle levels before the first frame
    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // one frame, msb first; the link clock stands still outside frames
    task automatic xfer(input int nbits, input logic [15:0] word, output logic [15:0] resp);
        resp = '0;
        spi_cs_n = 1'b0;
        #(HALF);
        for (int i = 0; i < nbits; i++)
        begin
            spi_sclk = 1'b1;
            spi_mosi = word[15 - i];
            #(HALF);
            spi_sclk = 1'b0;
            resp = {resp[14:0], spi_miso};
            #(HALF);
        end
        spi_cs_n = 1'b1;
        // released line shows the opposite level so a stale bit never looks valid
        spi_mosi = ~spi_mosi;
        // deselect gap well above eight system clocks
        #(GAP);
    endtask
endmodule

// ==== testbench/watchdog_diag_status_commands_tb.sv ====
// self-checking bench for the watchdog, diagnostic and status command core
// assumes the host model drives the link; status pins and watchdog inputs are driven here
`timescale 1ns/100ps
module watchdog_diag_status_commands_tb
    import wd_cmd_pkg::*;
;
    localparam int DLY = 1;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic spi_sclk, spi_cs_n, spi_mosi, spi_miso;
    logic sync_hot = 1'b0, dcreg_hot = 1'b0, boost_hot = 1'b0, supply_ok = 1'b1;
    logic wake_lvl = 1'b0;
    logic [1:0] wds = 2'h0;
    logic bad_ref = 1'b0, good_ref = 1'b0, sm_rst = 1'b0, int_rst = 1'b0;
    logic [3:0] pulse_vec;
    int err_count = 0, num_checks = 0;
    int cnt [4];
    logic [15:0] exp_resp = 16'h0E00, ack_w, err_w;
    logic boost_lat = 1'b0, supply_lat = 1'b1, cause = 1'b0;
    logic [7:0] d;
    logic [5:0] wo_id [3] = '{6'h0E, 6'h15, 6'h14};
    logic [3:0] wo_pulse [3] = '{4'h0, 4'h4, 4'h8};

    always #10 ref_clk = ~ref_clk;

    watchdog_diag_status_commands watchdog_diag_status_commands_inst (
        .ref_clk(ref_clk), .srst(srst),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .sync_supply_overtemp(sync_hot), .dc_sensor_reg_overtemp(dcreg_hot),
        .boost_overtemp(boost_hot), .ignition_level_monitor(supply_ok),
        .wake_pin_level(wake_lvl), .wd_state(wds), .wd_refresh_bad(bad_ref),
        .wd_refresh_good(good_ref), .wd_sm_reset(sm_rst), .internal_reset(int_rst),
        .watchdog_service_low(pulse_vec[0]), .watchdog_service_high(pulse_vec[1]),
        .watchdog_selftest_cmd(pulse_vec[2]), .diagnostic_default_cmd(pulse_vec[3])
    );

    spi_host_model spi_host_model_inst (
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso)
    );

    // count command pulses; a one-cycle pulse is seen at exactly one edge
    always @(posedge ref_clk)
    begin
        for (int i = 0; i < 4; i++)
            if (pulse_vec[i] === 1'b1)
                cnt[i]++;
    end

    // expected reply word, odd parity over all sixteen bits
    function automatic logic [15:0] resp_of(input logic [2:0] hdr, input logic [7:0] data);
        logic [15:0] w;
        w = {hdr, 1'b0, 4'hE, data};
        w[12] = ~(^w);
        return w;
    endfunction

    function automatic logic [7:0] stat();
        return {sync_hot, dcreg_hot, boost_lat, supply_lat, wake_lvl, wds, cause};
    endfunction

    task automatic check_resp(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_pulses(input logic [3:0] exp);
        num_checks++;
        for (int i = 0; i < 4; i++)
        begin
            if (cnt[i] != int'(exp[i]))
            begin
                err_count++;
                $display("[FAIL] pulse %0d expected %0d seen %0d", i, exp[i], cnt[i]);
            end
            cnt[i] = 0;
        end
    endtask

    // the reply to a frame comes out during the next one, so check the held one here
    task automatic cmd(input int nbits, input logic [15:0] word, input logic [3:0] exp_p,
        input logic [15:0] exp_new);
        logic [15:0] got;
        spi_host_model_inst.xfer(nbits, word, got);
        if (nbits == FRAME_BITS)
            check_resp("response", exp_resp, got);
        repeat (12) @(posedge ref_clk);
        #(DLY);
        check_pulses(exp_p);
        exp_resp = exp_new;
    endtask

    // a status read releases the latches, which then follow their live condition
    task automatic rd_status();
        cmd(16, 16'h9600, 4'h0, resp_of(3'h2, stat()));
        boost_lat = boost_hot;
        supply_lat = supply_ok;
    endtask

    // wait out the pin synchronisers, then note what the latches caught
    task automatic settle();
        repeat (6) @(posedge ref_clk);
        #(DLY);
        if (boost_hot)
            boost_lat = 1'b1;
        if (!supply_ok)
            supply_lat = 1'b0;
    endtask

    task automatic wd_pulse(input int which);
        case (which)
            0: bad_ref = 1'b1;
            1: good_ref = 1'b1;
            2: sm_rst = 1'b1;
            default: int_rst = 1'b1;
        endcase
        @(posedge ref_clk);
        #(DLY);
        {bad_ref, good_ref, sm_rst, int_rst} = 4'h0;
        @(posedge ref_clk);
        #(DLY);
        if (which < 3)
            cause = (which == 0);
        else
        begin
            boost_lat = boost_hot;
            supply_lat = supply_ok;
        end
    endtask

    task automatic do_reset();
        srst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #(DLY);
        srst = 1'b0;
        repeat (4) @(posedge ref_clk);
        #(DLY);
        {cause, boost_lat, supply_lat} = 3'h1;
        exp_resp = 16'h0E00;
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        void'($urandom(32'hDDB9D774));
        ack_w = resp_of(3'h1, 8'h00);
        err_w = resp_of(3'h0, 8'h02);
        do_reset();
        rd_status();
        end_test("reset");
        cmd(16, 16'h4E55, 4'h1, ack_w);
        cmd(16, 16'h4EAA, 4'h2, ack_w);
        d = 8'($urandom());
        if (d == 8'h55 || d == 8'hAA)
            d = 8'h3C;
        cmd(16, {8'h4E, d}, 4'h0, ack_w);
        end_test("service");
        for (int k = 0; k < 3; k++)
        begin
            d = 8'($urandom());
            if (d == 8'h55 || d == 8'hAA)
                d = 8'h0F;
            cmd(16, {2'h1, wo_id[k], d}, wo_pulse[k], ack_w);
            cmd(16, {2'h2, wo_id[k], d}, 4'h0, err_w);
        end
        cmd(16, 16'h5600, 4'h0, err_w);
        cmd(16, 16'h1600, 4'h0, err_w);
        cmd(16, 16'hD600, 4'h0, err_w);
        cmd(8, 16'h4E55, 4'h0, exp_resp);
        end_test("write_only");
        for (int k = 0; k < 4; k++)
        begin
            {sync_hot, dcreg_hot, wake_lvl} = 3'($urandom());
            wds = 2'(k);
            settle();
            rd_status();
        end
        end_test("status");
        {boost_hot, supply_ok} = 2'h2;
        settle();
        {boost_hot, supply_ok} = 2'h1;
        settle();
        rd_status();
        rd_status();
        boost_hot = 1'b1;
        settle();
        rd_status();
        boost_hot = 1'b0;
        settle();
        wd_pulse(3);
        rd_status();
        // condition arrives one cycle after the internal release and must be caught again
        boost_hot = 1'b1;
        @(posedge ref_clk);
        #(DLY);
        wd_pulse(3);
        boost_hot = 1'b0;
        settle();
        rd_status();
        end_test("latch");
        wd_pulse(0);
        rd_status();
        wd_pulse(1);
        rd_status();
        wd_pulse(0);
        wd_pulse(2);
        rd_status();
        wd_pulse(0);
        do_reset();
        rd_status();
        cmd(16, 16'h4EAA, 4'h2, ack_w);
        end_test("cause");
        end_sim();
    end

    // hang guard, far beyond the few dozen frames of the run
    initial
    begin
        #(400000);
        err_count++;
        $display("[FAIL] run expected finish seen timeout");
        end_sim();
    end
endmodule
